/* design/baud_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module baud_gen (
	input wire logic clk, // Master clock
	input wire logic srst, // Synchronous reset
	baud_if.gen bif // Configuration in, ticks out
);
	import usart_pkg::*;

	logic [2:0] pre_cnt, next_pre_cnt;
	logic sck_prev;
	logic [16:0] div_cnt, next_div_cnt;
	logic [2:0] acc, next_acc;
	logic [4:0] os_cnt, next_os_cnt;
	logic [10:0] ratio_cnt, next_ratio_cnt;
	logic next_sck, next_bit, next_sample;
	logic src_en, ext_rise, div_tick, frac_on;
	logic [3:0] acc_sum;
	logic [16:0] period, half;

	always_comb begin
		ext_rise = bif.sck_in & ~sck_prev;
		case (bif.source) // R23
			SRC_MCK: src_en = 1'b1;
			SRC_MCK_DIV: src_en = (pre_cnt == MCK_DIV_LAST);
			SRC_EXT: src_en = ext_rise;
			default: src_en = 1'b0;
		endcase
		frac_on = bif.normal & ~bif.sync & (bif.fraction != 3'h0); // R3 R4
		acc_sum = {1'b0, acc} + {1'b0, bif.fraction};
		period = {1'b0, bif.divisor} + {16'h0000, frac_on & (acc_sum >= FRACTION_ONE)}; // R3
		half = (period + 17'h00001) >> 1;
		next_pre_cnt = pre_cnt + 3'h1;
		next_div_cnt = div_cnt;
		next_acc = acc;
		next_sck = bif.sck_level;
		div_tick = 1'b0;
		if (src_en && bif.divisor != 16'h0000) begin // R22
			if (div_cnt >= period - 17'h00001) begin
				next_div_cnt = 17'h00000;
				div_tick = 1'b1;
				if (frac_on)
					next_acc = acc_sum[2:0];
			end else begin
				next_div_cnt = div_cnt + 17'h00001;
			end
			if (bif.divisor == 16'h0001)
				next_sck = ~bif.sck_level; // R22
			else
				next_sck = (next_div_cnt < half); // R9
		end
		next_os_cnt = os_cnt;
		next_ratio_cnt = ratio_cnt;
		next_sample = 1'b0;
		next_bit = 1'b0;
		if (bif.card) begin
			if (div_tick && bif.ratio != 11'h000) begin // R13
				if (ratio_cnt >= bif.ratio - 11'h001) begin
					next_ratio_cnt = 11'h000;
					next_bit = 1'b1;
				end else begin
					next_ratio_cnt = ratio_cnt + 11'h001;
				end
			end
		end else if (bif.sync && bif.source == SRC_EXT) begin
			next_bit = ext_rise; // R6
		end else if (bif.sync) begin
			next_bit = div_tick; // R5
		end else if (div_tick) begin
			next_sample = 1'b1; // R24
			if (os_cnt >= (bif.over ? OVERSAMPLE_8 : OVERSAMPLE_16) - 5'h01) begin // R1 R24
				next_os_cnt = 5'h00;
				next_bit = 1'b1;
			end else begin
				next_os_cnt = os_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || bif.restart) begin // R25
			pre_cnt <= 3'h0;
			sck_prev <= 1'b0;
			div_cnt <= 17'h00000;
			acc <= 3'h0;
			os_cnt <= 5'h00;
			ratio_cnt <= 11'h000;
			bif.sck_level <= 1'b0;
			bif.bit_tick <= 1'b0;
			bif.sample_tick <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			sck_prev <= bif.sck_in;
			div_cnt <= next_div_cnt;
			acc <= next_acc;
			os_cnt <= next_os_cnt;
			ratio_cnt <= next_ratio_cnt;
			bif.sck_level <= next_sck;
			bif.bit_tick <= next_bit;
			bif.sample_tick <= next_sample;
		end
	end
endmodule : baud_gen
`default_nettype wire

/* design/usart_ctrl_top.sv */
// What this block does
// R1 - Async 16x mode: bit rate is clock over sixteen times clock_divisor.
// R2 - Software keeps bit-rate error at or below five percent.
// R3 - Nonzero fraction_eighths adds eighths to the divisor.
// R4 - Fractional division only in normal serial mode.
// R5 - Synchronous mode: bit clock is source divided by clock_divisor only.
// R6 - Synchronous with external source: bit clock is the pin, divisor ignored.
// R7 - External clock stays at least 4.5 times below the system clock.
// R8 - Software uses even clock_divisor for balanced external or divided source.
// R9 - Master clock source gives balanced serial clock even for odd divisor; here odd divisors above one hold the clock high one cycle longer than low.
// R10 - rate_adjust_code decodes to factors 1,2,4,8,16,32,12,20.
// R11 - clock_factor_code decodes to the listed division factors.
// R12 - Smart card: divided source drives the pin when card_clock_drive set.
// R13 - Smart card: card clock divided by card_sample_divisor up to 2047.
// R14 - Software loads the nearest integer ratio.
// R15 - card_sample_divisor resets to 372.
// R16 - Receiver off after reset, on by command, configurable while off.
// R17 - Transmitter off after reset, on by command, configurable while off.
// R18 - Receiver and transmitter enable independently or together.
// R19 - Soft resets abort the corresponding side at once.
// R20 - Receiver off command finishes the current character first.
// R21 - Transmitter off command drains current and held character first.
// R22 - Divisor zero stops the generator; one bypasses it.
// R23 - Source select picks master clock, master clock over eight, or pin.
// R24 - Async sampling at 8 or 16 times the bit rate.
// R25 - Divider counters restart when divisor settings are rewritten.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module usart_ctrl_top #(
	parameter int DATA_W = 8
) (
	input wire logic REF_CLK, // Master clock
	input wire logic SRST, // Synchronous reset, active high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error on unmapped address
	input wire logic RXD, // Serial receive data
	input wire logic SCK_IN, // Serial clock pin input
	output logic SCK_OUT, // Serial clock pin output
	output logic SCK_OE_N, // Serial clock drive enable, low drives
	output logic TXD // Serial transmit data
);
	import usart_pkg::*;

	localparam int CHAR_BITS = DATA_W + 2;
	localparam logic [3:0] LAST_BIT = 4'(CHAR_BITS);

	if (DATA_W < 5 || DATA_W > 9) begin : g_check
		$error("DATA_W must lie between 5 and 9");
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] mode_reg, next_mode_reg;
	logic [15:0] clock_divisor, next_clock_divisor;
	logic [2:0] fraction_eighths, next_fraction_eighths;
	logic [10:0] card_sample_divisor, next_card_sample_divisor;
	logic [3:0] rate_adjust_code, next_rate_adjust_code;
	logic [3:0] clock_factor_code, next_clock_factor_code;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, restart, next_restart;
	logic access, wr, rd, hit, cmd;
	logic [31:0] status;

	rx_state_e rx_state, next_rx_state;
	logic rx_off_pend, next_rx_off_pend;
	logic [3:0] rx_cnt, next_rx_cnt;
	tx_state_e tx_state, next_tx_state;
	logic tx_off_pend, next_tx_off_pend;
	logic hold_full, next_hold_full;
	logic [DATA_W-1:0] hold_data, next_hold_data;
	logic [CHAR_BITS-1:0] tx_shift, next_tx_shift;
	logic [3:0] tx_cnt, next_tx_cnt;
	logic next_txd, next_sck_out, next_sck_oe_n;
	logic card_mode;

	baud_if bif();

	baud_gen u_baud_gen (
		.clk(REF_CLK),
		.srst(SRST),
		.bif(bif.gen)
	);

	always_comb begin
		card_mode = (mode_reg[MR_MODE_LSB +: 4] == OPMODE_CARD_T0) || (mode_reg[MR_MODE_LSB +: 4] == OPMODE_CARD_T1);
		bif.divisor = clock_divisor;
		bif.fraction = fraction_eighths;
		bif.source = mode_reg[MR_SRC_LSB +: 2];
		bif.over = mode_reg[MR_OVER];
		bif.sync = mode_reg[MR_SYNC];
		bif.card = card_mode;
		bif.normal = (mode_reg[MR_MODE_LSB +: 4] == OPMODE_NORMAL); // R4
		bif.ratio = card_sample_divisor;
		bif.restart = restart;
		bif.sck_in = SCK_IN;
	end

	always_comb begin
		access = PSEL & PENABLE;
		wr = access & PREADY & PWRITE;
		rd = access & ~PREADY & ~PWRITE;
		cmd = wr && PADDR == OFS_CONTROL;
		hit = PADDR == OFS_CONTROL || PADDR == OFS_MODE || PADDR == OFS_STATUS || PADDR == OFS_HOLDING
			|| PADDR == OFS_BAUD || PADDR == OFS_RATIO || PADDR == OFS_FACTOR;
		status = {26'h0000000, tx_state == TX_IDLE && !hold_full, tx_state != TX_OFF && !hold_full,
			tx_state == TX_SHIFT, rx_state == RX_BUSY, tx_state != TX_OFF, rx_state != RX_OFF};
		next_pready = access & ~PREADY;
		next_pslverr = access & ~PREADY & ~hit;
		next_prdata = PRDATA;
		if (rd) begin
			case (PADDR)
				OFS_MODE: next_prdata = mode_reg;
				OFS_STATUS: next_prdata = status;
				OFS_BAUD: next_prdata = {13'h0000, fraction_eighths, clock_divisor};
				OFS_RATIO: next_prdata = {21'h000000, card_sample_divisor};
				OFS_FACTOR: next_prdata = {clock_factor(clock_factor_code), 2'h0, rate_adjust(rate_adjust_code), // R10 R11
					4'h0, clock_factor_code, rate_adjust_code};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		next_mode_reg = mode_reg;
		next_clock_divisor = clock_divisor;
		next_fraction_eighths = fraction_eighths;
		next_card_sample_divisor = card_sample_divisor;
		next_rate_adjust_code = rate_adjust_code;
		next_clock_factor_code = clock_factor_code;
		next_restart = 1'b0;
		if (wr) begin
			case (PADDR)
				OFS_MODE: begin
					next_mode_reg = PWDATA & MODE_MASK; // R16 R17
					next_restart = 1'b1;
				end
				OFS_BAUD: begin
					next_clock_divisor = PWDATA[15:0];
					next_fraction_eighths = PWDATA[BR_FP_LSB +: 3];
					next_restart = 1'b1; // R25
				end
				OFS_RATIO: begin
					next_card_sample_divisor = PWDATA[10:0]; // R13
					next_restart = 1'b1; // R25
				end
				OFS_FACTOR: begin
					next_rate_adjust_code = PWDATA[3:0];
					next_clock_factor_code = PWDATA[FR_FI_LSB +: 4];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			mode_reg <= 32'h0000_0000;
			clock_divisor <= 16'h0000;
			fraction_eighths <= 3'h0;
			card_sample_divisor <= RATIO_RESET; // R15
			rate_adjust_code <= 4'h1;
			clock_factor_code <= 4'h1;
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			restart <= 1'b0;
		end else begin
			mode_reg <= next_mode_reg;
			clock_divisor <= next_clock_divisor;
			fraction_eighths <= next_fraction_eighths;
			card_sample_divisor <= next_card_sample_divisor;
			rate_adjust_code <= next_rate_adjust_code;
			clock_factor_code <= next_clock_factor_code;
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
			restart <= next_restart;
		end
	end

	// ----------------------------------------
	// Receiver control
	// ----------------------------------------
	always_comb begin
		next_rx_state = rx_state;
		next_rx_off_pend = rx_off_pend;
		next_rx_cnt = rx_cnt;
		case (rx_state)
			RX_OFF: if (cmd && PWDATA[CR_RX_ON] && !PWDATA[CR_RX_OFF]) next_rx_state = RX_IDLE; // R16 R18
			RX_IDLE: begin
				if (cmd && PWDATA[CR_RX_OFF]) begin
					next_rx_state = RX_OFF;
				end else if (bif.bit_tick && !RXD) begin
					next_rx_state = RX_BUSY;
					next_rx_cnt = 4'h1;
				end
			end
			RX_BUSY: begin
				if (cmd && PWDATA[CR_RX_OFF])
					next_rx_off_pend = 1'b1; // R20
				if (bif.bit_tick) begin
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == LAST_BIT - 4'h1) begin
						next_rx_state = (rx_off_pend || (cmd && PWDATA[CR_RX_OFF])) ? RX_OFF : RX_IDLE; // R20
						next_rx_off_pend = 1'b0;
					end
				end
			end
			default: next_rx_state = RX_OFF;
		endcase
		if (cmd && PWDATA[CR_RX_SRST]) begin // R19
			next_rx_state = RX_OFF;
			next_rx_off_pend = 1'b0;
			next_rx_cnt = 4'h0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			rx_state <= RX_OFF; // R16
			rx_off_pend <= 1'b0;
			rx_cnt <= 4'h0;
		end else begin
			rx_state <= next_rx_state;
			rx_off_pend <= next_rx_off_pend;
			rx_cnt <= next_rx_cnt;
		end
	end

	// ----------------------------------------
	// Transmitter control
	// ----------------------------------------
	always_comb begin
		next_tx_state = tx_state;
		next_tx_off_pend = tx_off_pend;
		next_hold_full = hold_full;
		next_hold_data = hold_data;
		next_tx_shift = tx_shift;
		next_tx_cnt = tx_cnt;
		next_txd = TXD;
		if (wr && PADDR == OFS_HOLDING && tx_state != TX_OFF && !hold_full) begin
			next_hold_full = 1'b1;
			next_hold_data = PWDATA[DATA_W-1:0];
		end
		case (tx_state)
			TX_OFF: if (cmd && PWDATA[CR_TX_ON] && !PWDATA[CR_TX_OFF]) next_tx_state = TX_IDLE; // R17 R18
			TX_IDLE: begin
				if (cmd && PWDATA[CR_TX_OFF])
					next_tx_off_pend = 1'b1;
				if (hold_full) begin
					next_tx_state = TX_SHIFT;
					next_tx_shift = {1'b1, hold_data, 1'b0};
					next_tx_cnt = 4'h0;
					next_hold_full = 1'b0;
				end else if (tx_off_pend || (cmd && PWDATA[CR_TX_OFF])) begin
					next_tx_state = TX_OFF;
					next_tx_off_pend = 1'b0;
				end
			end
			TX_SHIFT: begin
				if (cmd && PWDATA[CR_TX_OFF])
					next_tx_off_pend = 1'b1; // R21
				if (bif.bit_tick) begin
					if (tx_cnt == LAST_BIT) begin
						next_tx_state = TX_IDLE; // R21
					end else begin
						next_txd = tx_shift[0];
						next_tx_shift = {1'b1, tx_shift[CHAR_BITS-1:1]};
						next_tx_cnt = tx_cnt + 4'h1;
					end
				end
			end
			default: next_tx_state = TX_OFF;
		endcase
		if (cmd && PWDATA[CR_TX_SRST]) begin // R19
			next_tx_state = TX_OFF;
			next_tx_off_pend = 1'b0;
			next_hold_full = 1'b0;
			next_tx_cnt = 4'h0;
			next_txd = 1'b1;
		end
	end

	// ----------------------------------------
	// Serial clock pin
	// ----------------------------------------
	always_comb begin
		next_sck_out = bif.sck_level;
		if (card_mode)
			next_sck_oe_n = ~mode_reg[MR_CLK_DRIVE]; // R12
		else
			next_sck_oe_n = ~(mode_reg[MR_SYNC] && bif.source != SRC_EXT);
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			tx_state <= TX_OFF; // R17
			tx_off_pend <= 1'b0;
			hold_full <= 1'b0;
			hold_data <= '0;
			tx_shift <= '1;
			tx_cnt <= 4'h0;
			TXD <= 1'b1;
			SCK_OUT <= 1'b0;
			SCK_OE_N <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_off_pend <= next_tx_off_pend;
			hold_full <= next_hold_full;
			hold_data <= next_hold_data;
			tx_shift <= next_tx_shift;
			tx_cnt <= next_tx_cnt;
			TXD <= next_txd;
			SCK_OUT <= next_sck_out;
			SCK_OE_N <= next_sck_oe_n;
		end
	end
endmodule : usart_ctrl_top
`default_nettype wire

/* inc/baud_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface baud_if;
	logic [15:0] divisor;
	logic [2:0] fraction;
	logic [1:0] source;
	logic over;
	logic sync;
	logic card;
	logic normal;
	logic [10:0] ratio;
	logic restart;
	logic sck_in;
	logic bit_tick;
	logic sample_tick;
	logic sck_level;
	modport gen(input divisor, fraction, source, over, sync, card, normal, ratio, restart, sck_in,
		output bit_tick, sample_tick, sck_level);
	modport ctl(output divisor, fraction, source, over, sync, card, normal, ratio, restart, sck_in,
		input bit_tick, sample_tick, sck_level);
endinterface : baud_if
`default_nettype wire

/* inc/usart_pkg.sv */
package usart_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_HOLDING = 8'h1C;
	localparam logic [7:0] OFS_BAUD = 8'h20;
	localparam logic [7:0] OFS_RATIO = 8'h40;
	localparam logic [7:0] OFS_FACTOR = 8'h44;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CR_RX_SRST = 2;
	localparam int CR_TX_SRST = 3;
	localparam int CR_RX_ON = 4;
	localparam int CR_RX_OFF = 5;
	localparam int CR_TX_ON = 6;
	localparam int CR_TX_OFF = 7;
	localparam int MR_MODE_LSB = 0;
	localparam int MR_SRC_LSB = 4;
	localparam int MR_SYNC = 8;
	localparam int MR_CLK_DRIVE = 18;
	localparam int MR_OVER = 19;
	localparam int BR_FP_LSB = 16;
	localparam int FR_FI_LSB = 4;
	localparam logic [31:0] MODE_MASK = 32'h000C_013F;
	// ----------------------------------------
	// Encodings and reset values
	// ----------------------------------------
	localparam logic [3:0] OPMODE_NORMAL = 4'h0;
	localparam logic [3:0] OPMODE_CARD_T0 = 4'h4;
	localparam logic [3:0] OPMODE_CARD_T1 = 4'h6;
	localparam logic [1:0] SRC_MCK = 2'h0;
	localparam logic [1:0] SRC_MCK_DIV = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h3;
	localparam logic [2:0] MCK_DIV_LAST = 3'h7;
	localparam logic [4:0] OVERSAMPLE_16 = 5'h10;
	localparam logic [4:0] OVERSAMPLE_8 = 5'h08;
	localparam logic [10:0] RATIO_RESET = 11'h174;
	localparam logic [3:0] FRACTION_ONE = 4'h8;

	typedef enum logic [1:0] {RX_OFF, RX_IDLE, RX_BUSY} rx_state_e;
	typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SHIFT} tx_state_e;

	// Smart-card bit-rate adjustment factor
	function automatic logic [5:0] rate_adjust(input logic [3:0] code);
		case (code)
			4'h1: rate_adjust = 6'h01;
			4'h2: rate_adjust = 6'h02;
			4'h3: rate_adjust = 6'h04;
			4'h4: rate_adjust = 6'h08;
			4'h5: rate_adjust = 6'h10;
			4'h6: rate_adjust = 6'h20;
			4'h8: rate_adjust = 6'h0C;
			4'h9: rate_adjust = 6'h14;
			default: rate_adjust = 6'h00;
		endcase
	endfunction : rate_adjust

	// Smart-card clock division factor
	function automatic logic [11:0] clock_factor(input logic [3:0] code);
		case (code)
			4'h0, 4'h1: clock_factor = 12'h174;
			4'h2: clock_factor = 12'h22E;
			4'h3: clock_factor = 12'h2E8;
			4'h4: clock_factor = 12'h45C;
			4'h5: clock_factor = 12'h5D0;
			4'h6: clock_factor = 12'h744;
			4'h9: clock_factor = 12'h200;
			4'hA: clock_factor = 12'h300;
			4'hB: clock_factor = 12'h400;
			4'hC: clock_factor = 12'h600;
			4'hD: clock_factor = 12'h800;
			default: clock_factor = 12'h000;
		endcase
	endfunction : clock_factor
endpackage : usart_pkg

/* verification/remote_serial_model.sv */
`timescale 1ns/1ns
`default_nettype none
module remote_serial_model #(
	parameter int HALF_PERIOD = 5
) (
	input wire logic clk, // Master clock
	input wire logic ext_run, // Run the pin clock
	input wire logic send, // Pulse: send one frame
	input wire logic [7:0] data, // Frame payload
	input wire logic [15:0] bit_cycles, // Cycles per bit
	output logic rxd, // Line into the block
	output logic sck // Pin clock into the block
);
	logic [9:0] frame;
	int bits, cnt, half;
	always @(posedge clk) begin
		// Pin clock period is ten master cycles, stands low when not running
		if (ext_run) begin
			half <= (half == HALF_PERIOD - 1) ? 0 : half + 1;
			if (half == HALF_PERIOD - 1) sck <= !sck;
		end else begin
			half <= 0;
			sck <= 1'b0;
		end
		if (send) begin
			frame <= {1'b1, data, 1'b0};
			bits <= 10;
			cnt <= 0;
		end else if (bits != 0) begin
			rxd <= frame[0];
			cnt <= (cnt == bit_cycles - 1) ? 0 : cnt + 1;
			if (cnt == bit_cycles - 1) frame <= frame >> 1;
			if (cnt == bit_cycles - 1) bits <= bits - 1;
		end else begin
			rxd <= 1'b1;
		end
	end
endmodule : remote_serial_model
`default_nettype wire

/* verification/tb_usart_baud_and_enable_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_usart_baud_and_enable_control;
	import usart_pkg::*;
	typedef struct {logic [31:0] mode; logic [31:0] baud; logic [10:0] ratio; int exp; int tol;} row_s;
	logic REF_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD, SCK_IN, SCK_OUT, SCK_OE_N, TXD;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic ext_run, send;
	int n_mismatch, n_compared;
	int falls = 0;
	row_s rows[7];
	int di_tab[16] = '{0, 1, 2, 4, 8, 16, 32, 0, 12, 20, 0, 0, 0, 0, 0, 0};
	int fi_tab[16] = '{372, 372, 558, 744, 1116, 1488, 1860, 0, 0, 512, 768, 1024, 1536, 2048, 0, 0};
	usart_ctrl_top i_usart_ctrl_top (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.RXD(RXD), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .TXD(TXD));
	remote_serial_model i_remote_serial_model (.clk(REF_CLK), .ext_run(ext_run), .send(send), .data(8'h00),
		.bit_cycles(16'h0020), .rxd(RXD), .sck(SCK_IN));
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = !REF_CLK;
	end
	always @(posedge REF_CLK) if ($fell(TXD)) falls <= falls + 1;
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic bad(input string s);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, s);
	endtask : bad
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
		if (n >= 50) begin
			bad("bus timeout");
			tally_and_finish();
		end
	endtask : apb
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wreg
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		n_compared++;
		if ((r & m) !== (x & m)) bad("read value");
	endtask : chk
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0, r, e);
			n++;
		end while ((r & m) !== v && n < 3000);
		if (n >= 3000) begin
			bad("status timeout");
			tally_and_finish();
		end
	endtask : wait_st
	task automatic low_run(output int len);
		int n;
		n = 0;
		len = 0;
		while (TXD !== 1'b0 && n < 30000) begin
			@(posedge REF_CLK);
			n++;
		end
		while (TXD === 1'b0 && len < 30000) begin
			@(posedge REF_CLK);
			len++;
		end
		if (n >= 30000 || len >= 30000) begin
			bad("line timeout");
			tally_and_finish();
		end
	endtask : low_run
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r, x;
		logic e;
		int len, d, f0;
		{SRST, PSEL, PENABLE, PWRITE, ext_run, send} = 6'h20;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		{n_mismatch, n_compared} = 64'h0;
		// Divisors 0, 1, 2 and 4, one row with four eighths added; frame of zero data is nine low bits
		rows = '{'{32'h0, 32'h2, 11'h174, 288, 2}, '{32'h0008_0000, 32'h2, 11'h174, 144, 2},
			'{32'h0, 32'h0004_0002, 11'h174, 360, 3}, '{32'h0000_0010, 32'h1, 11'h174, 1152, 9},
			'{32'h0000_0100, 32'h4, 11'h174, 36, 4}, '{32'h0000_0130, 32'h0, 11'h174, 90, 10},
			'{32'h0004_0004, 32'h0004_0002, 11'h005, 90, 2}};
		repeat (5) @(posedge REF_CLK);
		SRST <= 1'b0;
		@(posedge REF_CLK);
		for (int i = 0; i < 7; i++) begin
			ext_run <= (rows[i].mode[5:4] == SRC_EXT);
			wreg(OFS_MODE, rows[i].mode);
			wreg(OFS_BAUD, rows[i].baud);
			wreg(OFS_RATIO, {21'h0, rows[i].ratio});
			wreg(OFS_CONTROL, 32'h40);
			wreg(OFS_HOLDING, 32'h0);
			low_run(len);
			d = len - rows[i].exp;
			n_compared++;
			if (d > rows[i].tol || d < -rows[i].tol) bad("bit time");
			if (rows[i].mode[MR_CLK_DRIVE] && SCK_OE_N !== 1'b0) bad("card clock not driven");
			wait_st(32'h20, 32'h20);
		end
		SRST <= 1'b1;
		ext_run <= 1'b0;
		repeat (5) @(posedge REF_CLK);
		SRST <= 1'b0;
		@(posedge REF_CLK);
		chk(OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
		chk(OFS_RATIO, 32'hFFFF_FFFF, 32'h174);
		chk(OFS_BAUD, 32'hFFFF_FFFF, 32'h0);
		chk(OFS_CONTROL, 32'hFFFF_FFFF, 32'h0);
		apb(1'b0, 8'h08, 32'h0, r, e);
		n_compared++;
		if (r !== 32'h0 || e !== 1'b1) bad("unmapped access");
		for (int c = 0; c < 16; c++) begin
			x = (32'(fi_tab[c]) << 20) | (32'(di_tab[c]) << 12) | {24'h0, 4'(c), 4'(c)};
			wreg(OFS_FACTOR, {24'h0, 4'(c), 4'(c)});
			chk(OFS_FACTOR, 32'hFFFF_FFFF, x);
		end
		wreg(OFS_CONTROL, 32'h10);
		chk(OFS_STATUS, 32'h3, 32'h1);
		wreg(OFS_CONTROL, 32'h0C);
		wreg(OFS_CONTROL, 32'h50);
		chk(OFS_STATUS, 32'h3, 32'h3);
		wreg(OFS_CONTROL, 32'hA0);
		wreg(OFS_CONTROL, 32'hC0);
		chk(OFS_STATUS, 32'h3, 32'h0);
		wreg(OFS_BAUD, 32'h2);
		wreg(OFS_CONTROL, 32'h40);
		f0 = falls;
		wreg(OFS_HOLDING, 32'h0);
		wreg(OFS_HOLDING, 32'h0);
		wreg(OFS_CONTROL, 32'h80);
		wait_st(32'h0A, 32'h0);
		n_compared++;
		if (falls - f0 !== 2) bad("drain count");
		wreg(OFS_CONTROL, 32'h40);
		wreg(OFS_HOLDING, 32'h0);
		wait_st(32'h08, 32'h08);
		wreg(OFS_CONTROL, 32'h08);
		chk(OFS_STATUS, 32'h0A, 32'h0);
		wreg(OFS_CONTROL, 32'h10);
		send <= 1'b1;
		@(posedge REF_CLK);
		send <= 1'b0;
		wait_st(32'h4, 32'h4);
		wreg(OFS_CONTROL, 32'h20);
		chk(OFS_STATUS, 32'h4, 32'h4);
		wait_st(32'h5, 32'h0);
		send <= 1'b1;
		@(posedge REF_CLK);
		send <= 1'b0;
		repeat (100) @(posedge REF_CLK);
		chk(OFS_STATUS, 32'h4, 32'h0);
		wreg(OFS_CONTROL, 32'h10);
		send <= 1'b1;
		@(posedge REF_CLK);
		send <= 1'b0;
		wait_st(32'h4, 32'h4);
		wreg(OFS_CONTROL, 32'h04);
		chk(OFS_STATUS, 32'h5, 32'h0);
		tally_and_finish();
	end
endmodule : tb_usart_baud_and_enable_control
`default_nettype wire

/* verification/usart_ctrl_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module usart_ctrl_asserts (
	input wire logic REF_CLK, // Clock
	input wire logic SRST, // Reset
	input wire logic PSEL, // Select
	input wire logic PENABLE, // Enable
	input wire logic PWRITE, // Direction
	input wire logic [7:0] PADDR, // Address
	input wire logic [31:0] PWDATA, // Write data
	input wire logic [31:0] PRDATA, // Read data
	input wire logic PREADY, // Ready
	input wire logic PSLVERR, // Error
	input wire logic SCK_OUT, // Pin clock out
	input wire logic SCK_OE_N, // Pin drive enable
	input wire logic TXD // Serial out
);
	import usart_pkg::*;
	// ----------------------------------------
	// Shadow of the mode, divisor and transmitter enable
	// ----------------------------------------
	logic wr, mapped, drive_ok, tx_seen, next_tx_seen, div_zero, next_div_zero;
	logic [31:0] mode, next_mode;
	assign wr = PSEL && PENABLE && PREADY && PWRITE;
	assign mapped = PADDR inside {OFS_CONTROL, OFS_MODE, OFS_STATUS, OFS_HOLDING, OFS_BAUD, OFS_RATIO, OFS_FACTOR};
	assign drive_ok = (mode[MR_SYNC] && mode[5:4] != SRC_EXT)
		|| (mode[3:0] inside {OPMODE_CARD_T0, OPMODE_CARD_T1} && mode[MR_CLK_DRIVE]);
	always_comb begin
		next_mode = (wr && PADDR == OFS_MODE) ? (PWDATA & MODE_MASK) : mode;
		next_div_zero = (wr && PADDR == OFS_BAUD) ? (PWDATA[15:0] == 16'h0000) : div_zero;
		next_tx_seen = tx_seen;
		if (wr && PADDR == OFS_CONTROL && PWDATA[CR_TX_ON]) next_tx_seen = 1'b1;
		if (wr && PADDR == OFS_CONTROL && PWDATA[CR_TX_SRST]) next_tx_seen = 1'b0;
	end
	always_ff @(posedge REF_CLK) begin
		mode <= SRST ? 32'h0 : next_mode;
		div_zero <= SRST ? 1'b1 : next_div_zero;
		tx_seen <= SRST ? 1'b0 : next_tx_seen;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	a_ready_wait: assert property (
		PSEL && !PENABLE |=> !PREADY ##1 PREADY) else $error("ready not in second access cycle");
	a_ready_pulse: assert property (
		PREADY |=> !PREADY) else $error("ready longer than one cycle");
	a_err_unmapped: assert property (
		PREADY |-> PSLVERR == !mapped) else $error("error flag wrong for address");
	a_read_zero: assert property (
		PREADY && !PWRITE && (!mapped || PADDR == OFS_CONTROL) |-> PRDATA == 32'h0) else $error("read not zero");
	a_reset_idle: assert property (
		$fell(SRST) |-> TXD && SCK_OE_N && !PREADY) else $error("outputs not idle after reset");
	a_tx_quiet: assert property (
		!tx_seen && !$past(tx_seen) |-> TXD) else $error("line active while transmitter off");
	a_sck_release: assert property (
		!drive_ok && !$past(drive_ok) |-> SCK_OE_N) else $error("clock pin driven when not allowed");
	a_div_stop: assert property (
		div_zero && $past(div_zero, 3) && mode[5:4] != SRC_EXT |-> $stable(SCK_OUT)) else $error("clock runs at divisor zero");
	c_mode_write: cover property (wr && PADDR == OFS_MODE);
	c_start_bit: cover property ($fell(TXD));
	c_pin_driven: cover property (!SCK_OE_N);
endmodule : usart_ctrl_asserts
bind usart_ctrl_top usart_ctrl_asserts i_usart_ctrl_asserts (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .TXD(TXD));
`default_nettype wire
